// ### core/lpbs_bank_fsm.sv
`timescale 1ns/1ps
// Functional notes
// - cke compared with previous edge; cs now
// - resetting power-down exit: idle if init done
// - activate goes through row activating, tRCD
// - refresh all busy until tRFCab, then idle
// - mode write busy until tMRW, then idle
// - mode read busy tMRR, prior state resumes
// - reset via mode write enters resetting
// - active: read, write, mode read, precharge
// - auto-precharge returns idle after burst plus tRP
// - reading: read restarts, write switches at once
// - writing: write restarts, read switches at once
// - burst terminate hits latest burst, any bank
// - precharge to idle bank still waits tRP
// - new burst honours its own auto-precharge
// - idle and active only after timings met
// - bank chosen from two bank address bits
// - auto-precharge bit precharges after burst
module lpbs_bank_fsm #(
    parameter int NUM_BANKS = 4,
    parameter int RCD_CYC   = lpbs_pkg::RCD_CYC,
    parameter int RP_CYC    = lpbs_pkg::RP_CYC,
    parameter int RFCAB_CYC = lpbs_pkg::RFCAB_CYC,
    parameter int MRW_CYC   = lpbs_pkg::MRW_CYC,
    parameter int MRR_CYC   = lpbs_pkg::MRR_CYC,
    parameter int XP_CYC    = lpbs_pkg::XP_CYC,
    parameter int XSR_CYC   = lpbs_pkg::XSR_CYC,
    parameter int BURST_CYC = lpbs_pkg::BURST_CYC,
    parameter int INIT5_CYC = lpbs_pkg::INIT5_CYC
) (
    // clock and reset
    input  wire logic                ref_clk,
    input  wire logic                reset,
    // command bus, decoded
    input  wire logic                cke,
    input  wire logic                cs_n,
    input  wire logic [3:0]          cmd,
    input  wire logic [1:0]          bank_addr,
    input  wire logic                auto_pre,
    input  wire logic                self_refresh,
    // status
    output logic [4*NUM_BANKS-1:0]   bank_state,
    output logic [2:0]               power_state,
    output logic                     all_idle,
    output logic                     cmd_illegal
);

    if (NUM_BANKS != 4)
    begin : g_bad_banks
        $error("two bank address bits serve exactly four banks");
    end
    if (INIT5_CYC >= (1 << lpbs_pkg::CNT_W) * 256 || RFCAB_CYC >= (1 << lpbs_pkg::CNT_W))
    begin : g_bad_counts
        $error("timing count exceeds counter width");
    end

    localparam int IW = 32;

    ////////////////////////////////////////////////////////////////////////////////
    // command qualification

    lpbs_pkg::lpbs_state_e st      [NUM_BANKS];
    logic [lpbs_pkg::CNT_W-1:0] cnt [NUM_BANKS];
    logic                  cke_prev;
    lpbs_pkg::lpbs_pwr_e   pwr;
    logic [lpbs_pkg::CNT_W-1:0] pwr_cnt;
    logic [IW-1:0]         init_cnt;
    logic                  init_done;
    logic [1:0]            last_burst_bank;
    logic                  burst_live;
    logic                  next_illegal;
    lpbs_pkg::lpbs_cmd_e   c;
    logic                  cmd_ok;

    function automatic logic [lpbs_pkg::CNT_W-1:0] ld(input int n);
        return lpbs_pkg::CNT_W'(n - 1);
    endfunction : ld

    function automatic logic is_burst(input lpbs_pkg::lpbs_state_e s);
        return s == lpbs_pkg::LPBS_READING || s == lpbs_pkg::LPBS_WRITING;
    endfunction : is_burst

    assign c = lpbs_pkg::lpbs_cmd_e'(cmd);
    // command table applies only with cke high at both edges and exit waits over
    assign cmd_ok = cke_prev && cke && !cs_n && pwr == lpbs_pkg::LPBS_PWR_RUN;

    always_comb
    begin
        all_idle = 1'b1;
        for (int b = 0; b < NUM_BANKS; b++)
            if (st[b] != lpbs_pkg::LPBS_IDLE)
                all_idle = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // legality check, no state changes on refusal

    always_comb
    begin
        lpbs_pkg::lpbs_state_e s;
        s = st[bank_addr];
        next_illegal = 1'b0;
        if (cmd_ok)
        begin
            case (c)
                lpbs_pkg::LPBS_CMD_NOP:  next_illegal = 1'b0;
                lpbs_pkg::LPBS_CMD_ACT:  next_illegal = s != lpbs_pkg::LPBS_IDLE;
                lpbs_pkg::LPBS_CMD_RD,
                lpbs_pkg::LPBS_CMD_WR:   next_illegal = !(s == lpbs_pkg::LPBS_ACTIVE || is_burst(s));
                lpbs_pkg::LPBS_CMD_PRE:  next_illegal = !(s == lpbs_pkg::LPBS_ACTIVE
                                             || s == lpbs_pkg::LPBS_IDLE || is_burst(s));
                lpbs_pkg::LPBS_CMD_PREA:
                begin
                    for (int b = 0; b < NUM_BANKS; b++)
                        if (!(st[b] == lpbs_pkg::LPBS_ACTIVE || st[b] == lpbs_pkg::LPBS_IDLE
                              || is_burst(st[b])))
                            next_illegal = 1'b1;
                end
                lpbs_pkg::LPBS_CMD_REFA,
                lpbs_pkg::LPBS_CMD_MRW:  next_illegal = !all_idle;
                lpbs_pkg::LPBS_CMD_RESET:
                begin
                    next_illegal = 1'b0;
                    for (int b = 0; b < NUM_BANKS; b++)
                        if (!(st[b] == lpbs_pkg::LPBS_IDLE || st[b] == lpbs_pkg::LPBS_POWER_ON))
                            next_illegal = 1'b1;
                end
                lpbs_pkg::LPBS_CMD_MRR:  next_illegal = !(s == lpbs_pkg::LPBS_IDLE
                                             || s == lpbs_pkg::LPBS_ACTIVE
                                             || s == lpbs_pkg::LPBS_RESETTING);
                // the tracked burst may have just run out, so its bank is checked too
                lpbs_pkg::LPBS_CMD_BST:  next_illegal = !(burst_live
                                             && is_burst(st[last_burst_bank]));
                default:                 next_illegal = 1'b1;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
        if (reset)
            cmd_illegal <= 1'b0;
        else
            cmd_illegal <= next_illegal;

    ////////////////////////////////////////////////////////////////////////////////
    // power-down, self refresh and exit waits

    always_ff @(posedge ref_clk)
        if (reset)
            cke_prev <= 1'b0;
        else
            cke_prev <= cke;

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            pwr     <= lpbs_pkg::LPBS_PWR_RUN;
            pwr_cnt <= '0;
        end
        else
        begin
            case (pwr)
                lpbs_pkg::LPBS_PWR_RUN:
                    if (cke_prev && !cke)
                        pwr <= (self_refresh && !cs_n && all_idle) ? lpbs_pkg::LPBS_PWR_SREF
                                                                 : lpbs_pkg::LPBS_PWR_PD;
                lpbs_pkg::LPBS_PWR_PD:
                    if (!cke_prev && cke && cs_n)
                    begin
                        pwr     <= lpbs_pkg::LPBS_PWR_XP;
                        pwr_cnt <= ld(XP_CYC);
                    end
                lpbs_pkg::LPBS_PWR_SREF:
                    if (!cke_prev && cke && cs_n)
                    begin
                        pwr     <= lpbs_pkg::LPBS_PWR_XSR;
                        pwr_cnt <= ld(XSR_CYC);
                    end
                lpbs_pkg::LPBS_PWR_XP,
                lpbs_pkg::LPBS_PWR_XSR:
                    if (pwr_cnt == '0)
                        pwr <= lpbs_pkg::LPBS_PWR_RUN;
                    else
                        pwr_cnt <= pwr_cnt - 1'b1;
                default:
                    pwr <= lpbs_pkg::LPBS_PWR_RUN;
            endcase
        end
    end

    // auto-initialisation timer; a long count, so a parameter shortens it
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            init_cnt <= '0;
        else if (cmd_ok && c == lpbs_pkg::LPBS_CMD_RESET && !next_illegal)
            init_cnt <= IW'(INIT5_CYC);
        else if (init_cnt != '0)
            init_cnt <= init_cnt - 1'b1;
    end
    assign init_done = init_cnt == '0;

    ////////////////////////////////////////////////////////////////////////////////
    // most recent burst tracking for terminate

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            last_burst_bank <= '0;
            burst_live      <= 1'b0;
        end
        else if (cmd_ok && !next_illegal)
        begin
            if (c == lpbs_pkg::LPBS_CMD_RD || c == lpbs_pkg::LPBS_CMD_WR)
            begin
                last_burst_bank <= bank_addr;
                burst_live      <= !auto_pre;
            end
            else if (c == lpbs_pkg::LPBS_CMD_BST || c == lpbs_pkg::LPBS_CMD_PRE
                     || c == lpbs_pkg::LPBS_CMD_PREA)
                burst_live <= 1'b0;
        end
        else if (!is_burst(st[last_burst_bank]))
            burst_live <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // per-bank state machines

    for (genvar g = 0; g < NUM_BANKS; g++)
    begin : g_bank
        logic hit;
        logic go;
        assign hit = bank_addr == 2'(g);
        assign go  = cmd_ok && !next_illegal;
        assign bank_state[4*g +: 4] = st[g];

        always_ff @(posedge ref_clk)
        begin
            if (reset)
            begin
                st[g]  <= lpbs_pkg::LPBS_POWER_ON;
                cnt[g] <= '0;
            end
            else if (go && c == lpbs_pkg::LPBS_CMD_RESET)
                st[g] <= lpbs_pkg::LPBS_RESETTING;
            else if (go && c == lpbs_pkg::LPBS_CMD_REFA)
            begin
                st[g]  <= lpbs_pkg::LPBS_REFRESHING;
                cnt[g] <= ld(RFCAB_CYC);
            end
            else if (go && c == lpbs_pkg::LPBS_CMD_MRW)
            begin
                st[g]  <= lpbs_pkg::LPBS_MR_WRITING;
                cnt[g] <= ld(MRW_CYC);
            end
            else if (go && c == lpbs_pkg::LPBS_CMD_PREA)
            begin
                st[g]  <= lpbs_pkg::LPBS_PRECHARGING;
                cnt[g] <= ld(RP_CYC);
            end
            else if (go && c == lpbs_pkg::LPBS_CMD_BST && last_burst_bank == 2'(g))
                st[g] <= lpbs_pkg::LPBS_ACTIVE;
            else if (go && hit && c != lpbs_pkg::LPBS_CMD_NOP && c != lpbs_pkg::LPBS_CMD_BST)
            begin
                case (c)
                    lpbs_pkg::LPBS_CMD_ACT:
                    begin
                        st[g]  <= lpbs_pkg::LPBS_ROW_ACTIVATING;
                        cnt[g] <= ld(RCD_CYC);
                    end
                    lpbs_pkg::LPBS_CMD_RD:
                    begin
                        st[g]  <= auto_pre ? lpbs_pkg::LPBS_RD_AP : lpbs_pkg::LPBS_READING;
                        cnt[g] <= ld(auto_pre ? BURST_CYC + RP_CYC : BURST_CYC);
                    end
                    lpbs_pkg::LPBS_CMD_WR:
                    begin
                        st[g]  <= auto_pre ? lpbs_pkg::LPBS_WR_AP : lpbs_pkg::LPBS_WRITING;
                        cnt[g] <= ld(auto_pre ? BURST_CYC + RP_CYC : BURST_CYC);
                    end
                    lpbs_pkg::LPBS_CMD_PRE:
                    begin
                        st[g]  <= lpbs_pkg::LPBS_PRECHARGING;
                        cnt[g] <= ld(RP_CYC);
                    end
                    lpbs_pkg::LPBS_CMD_MRR:
                    begin
                        case (st[g])
                            lpbs_pkg::LPBS_ACTIVE:    st[g] <= lpbs_pkg::LPBS_ACTIVE_MRR;
                            lpbs_pkg::LPBS_RESETTING: st[g] <= lpbs_pkg::LPBS_RESETTING_MRR;
                            default:                  st[g] <= lpbs_pkg::LPBS_IDLE_MRR;
                        endcase
                        cnt[g] <= ld(MRR_CYC);
                    end
                    default: st[g] <= st[g];
                endcase
            end
            else
            begin
                // timed states: same-bank commands refused above until the count ends, except in reading and writing
                case (st[g])
                    lpbs_pkg::LPBS_ROW_ACTIVATING,
                    lpbs_pkg::LPBS_PRECHARGING,
                    lpbs_pkg::LPBS_REFRESHING,
                    lpbs_pkg::LPBS_MR_WRITING,
                    lpbs_pkg::LPBS_IDLE_MRR,
                    lpbs_pkg::LPBS_ACTIVE_MRR,
                    lpbs_pkg::LPBS_RESETTING_MRR,
                    lpbs_pkg::LPBS_RD_AP,
                    lpbs_pkg::LPBS_WR_AP,
                    lpbs_pkg::LPBS_READING,
                    lpbs_pkg::LPBS_WRITING:
                    begin
                        if (cnt[g] != '0)
                            cnt[g] <= cnt[g] - 1'b1;
                        else
                            case (st[g])
                                lpbs_pkg::LPBS_ROW_ACTIVATING,
                                lpbs_pkg::LPBS_ACTIVE_MRR,
                                lpbs_pkg::LPBS_READING,
                                lpbs_pkg::LPBS_WRITING:
                                    st[g] <= lpbs_pkg::LPBS_ACTIVE;
                                lpbs_pkg::LPBS_RESETTING_MRR:
                                    st[g] <= lpbs_pkg::LPBS_RESETTING;
                                default:
                                    st[g] <= lpbs_pkg::LPBS_IDLE;
                            endcase
                    end
                    lpbs_pkg::LPBS_RESETTING:
                        // power-down exit included: idle only after init interval
                        if (init_done && pwr == lpbs_pkg::LPBS_PWR_RUN)
                            st[g] <= lpbs_pkg::LPBS_IDLE;
                    default: st[g] <= st[g];
                endcase
            end
        end
    end

    assign power_state = pwr;

endmodule : lpbs_bank_fsm

// ### core/lpbs_pkg.sv
package lpbs_pkg;

    // decoded command codes presented by the command decoder
    typedef enum logic [3:0] {
        LPBS_CMD_NOP,
        LPBS_CMD_ACT,
        LPBS_CMD_RD,
        LPBS_CMD_WR,
        LPBS_CMD_PRE,
        LPBS_CMD_PREA,
        LPBS_CMD_REFA,
        LPBS_CMD_MRW,
        LPBS_CMD_MRR,
        LPBS_CMD_RESET,
        LPBS_CMD_BST
    } lpbs_cmd_e;

    // per-bank states
    typedef enum logic [3:0] {
        LPBS_POWER_ON,
        LPBS_IDLE,
        LPBS_ROW_ACTIVATING,
        LPBS_ACTIVE,
        LPBS_READING,
        LPBS_WRITING,
        LPBS_RD_AP,
        LPBS_WR_AP,
        LPBS_PRECHARGING,
        LPBS_REFRESHING,
        LPBS_MR_WRITING,
        LPBS_IDLE_MRR,
        LPBS_ACTIVE_MRR,
        LPBS_RESETTING,
        LPBS_RESETTING_MRR
    } lpbs_state_e;

    // device-level power states
    typedef enum logic [2:0] {
        LPBS_PWR_RUN,
        LPBS_PWR_PD,
        LPBS_PWR_SREF,
        LPBS_PWR_XP,
        LPBS_PWR_XSR
    } lpbs_pwr_e;

    localparam int CLK_PERIOD_PS = 10000;
    // timing figures in picoseconds, plain defaults
    localparam int T_RCD_PS   = 18000;
    localparam int T_RP_PS    = 18000;
    localparam int T_RFCAB_PS = 90000;
    localparam int T_MRW_PS   = 50000;
    localparam int T_MRR_PS   = 20000;
    localparam int T_XP_PS    = 7500;
    localparam int T_XSR_PS   = 100000;
    localparam int T_BURST_PS = 40000;
    localparam int T_INIT5_PS = 10000000;

    localparam int CNT_W = 16;

    function automatic int cyc(input int t_ps);
        int c;
        c = (t_ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction : cyc

    localparam int RCD_CYC   = cyc(T_RCD_PS);
    localparam int RP_CYC    = cyc(T_RP_PS);
    localparam int RFCAB_CYC = cyc(T_RFCAB_PS);
    localparam int MRW_CYC   = cyc(T_MRW_PS);
    localparam int MRR_CYC   = cyc(T_MRR_PS);
    localparam int XP_CYC    = cyc(T_XP_PS);
    localparam int XSR_CYC   = cyc(T_XSR_PS);
    localparam int BURST_CYC = cyc(T_BURST_PS);
    localparam int INIT5_CYC = cyc(T_INIT5_PS);

endpackage : lpbs_pkg

// ### verification/lpbs_bank_fsm_assertions.sv
`timescale 1ns/1ps
module lpbs_bank_fsm_assertions #(
    parameter int NUM_BANKS = 4
) (
    input wire logic                  ref_clk,
    input wire logic                  reset,
    input wire logic                  cke,
    input wire logic                  cs_n,
    input wire logic [3:0]            cmd,
    input wire logic [1:0]            bank_addr,
    input wire logic                  auto_pre,
    input wire logic                  self_refresh,
    input wire logic [4*NUM_BANKS-1:0] bank_state,
    input wire logic [2:0]            power_state,
    input wire logic                  all_idle,
    input wire logic                  cmd_illegal
);
    logic       ckep;
    wire logic  tk;
    wire logic [3:0] b0;
    ////////////////////////////////////////////////////////////////////////////
    // a command only counts when cke was high on both edges
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            ckep <= 1'b0;
        else
            ckep <= cke;
    end
    assign tk = ckep && cke && !cs_n && power_state == lpbs_pkg::LPBS_PWR_RUN;
    assign b0 = bank_state[3:0];
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////////////
    AST_ACT_OPEN: assert property (b0 == lpbs_pkg::LPBS_IDLE && tk && cmd == lpbs_pkg::LPBS_CMD_ACT
        && bank_addr == 2'h0 |=> b0 == lpbs_pkg::LPBS_ROW_ACTIVATING ##[1:4] b0 == lpbs_pkg::LPBS_ACTIVE)
        else $error("activate did not open bank 0");
    AST_WR_START: assert property (b0 == lpbs_pkg::LPBS_ACTIVE && tk && cmd == lpbs_pkg::LPBS_CMD_WR
        && !auto_pre && bank_addr == 2'h0 |=> b0 == lpbs_pkg::LPBS_WRITING)
        else $error("write from active did not start a burst");
    AST_RD_AP: assert property (b0 == lpbs_pkg::LPBS_READING && tk && cmd == lpbs_pkg::LPBS_CMD_RD
        && auto_pre && bank_addr == 2'h0 |=> b0 == lpbs_pkg::LPBS_RD_AP ##[1:20] b0 == lpbs_pkg::LPBS_IDLE)
        else $error("read with auto precharge did not close the bank");
    AST_PRE_IDLE: assert property (b0 == lpbs_pkg::LPBS_IDLE && tk && cmd == lpbs_pkg::LPBS_CMD_PRE
        && bank_addr == 2'h0 |=> b0 == lpbs_pkg::LPBS_PRECHARGING)
        else $error("precharge to idle bank skipped the wait");
    AST_REFA: assert property (all_idle && tk && cmd == lpbs_pkg::LPBS_CMD_REFA
        |=> b0 == lpbs_pkg::LPBS_REFRESHING ##[1:30] all_idle)
        else $error("refresh all did not run or never ended");
    AST_MRW: assert property (all_idle && tk && cmd == lpbs_pkg::LPBS_CMD_MRW
        |=> b0 == lpbs_pkg::LPBS_MR_WRITING ##[1:20] all_idle)
        else $error("mode write did not run or never ended");
    AST_RESET: assert property (b0 == lpbs_pkg::LPBS_POWER_ON && tk && cmd == lpbs_pkg::LPBS_CMD_RESET
        |=> b0 == lpbs_pkg::LPBS_RESETTING)
        else $error("reset command did not start initialisation");
    AST_BST: assert property (b0 == lpbs_pkg::LPBS_WRITING && tk && cmd == lpbs_pkg::LPBS_CMD_BST
        |=> b0 == lpbs_pkg::LPBS_ACTIVE)
        else $error("burst terminate did not leave bank active");
    AST_NOP_QUIET: assert property (tk && cmd == lpbs_pkg::LPBS_CMD_NOP |=> !cmd_illegal)
        else $error("nop flagged as illegal");
    AST_IDLE_HOLD: assert property (b0 == lpbs_pkg::LPBS_IDLE
        && !(tk && cmd != lpbs_pkg::LPBS_CMD_NOP) |=> b0 == lpbs_pkg::LPBS_IDLE)
        else $error("idle bank moved without a command");
    AST_PD_HOLD: assert property (power_state == lpbs_pkg::LPBS_PWR_PD && !cke
        |=> power_state == lpbs_pkg::LPBS_PWR_PD)
        else $error("power down left while cke low");
    COV_REFA: cover property (tk && cmd == lpbs_pkg::LPBS_CMD_REFA);
    COV_ILLEGAL: cover property (cmd_illegal);
    COV_XSR: cover property (power_state == lpbs_pkg::LPBS_PWR_XSR);
endmodule : lpbs_bank_fsm_assertions

bind lpbs_bank_fsm lpbs_bank_fsm_assertions #(.NUM_BANKS(NUM_BANKS)) u_chk (
    .ref_clk(ref_clk), .reset(reset), .cke(cke), .cs_n(cs_n), .cmd(cmd),
    .bank_addr(bank_addr), .auto_pre(auto_pre), .self_refresh(self_refresh),
    .bank_state(bank_state), .power_state(power_state), .all_idle(all_idle),
    .cmd_illegal(cmd_illegal));

// ### verification/lpbs_ctl_model.sv
`timescale 1ns/1ps
module lpbs_ctl_model (
    // clock
    input  wire logic       ref_clk,
    // command bus
    output logic            cke,
    output logic            cs_n,
    output logic [3:0]      cmd,
    output logic [1:0]      bank_addr,
    output logic            auto_pre,
    output logic            self_refresh
);
    initial
    begin
        cke          = 1'b1;
        cs_n         = 1'b0;
        cmd          = 4'h0;
        bank_addr    = 2'h0;
        auto_pre     = 1'b0;
        self_refresh = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // called at a falling edge; the command stays up until the next call
    task automatic send(input logic [3:0] c, input logic [1:0] b, input logic ap);
        cmd       = c;
        bank_addr = b;
        auto_pre  = ap;
        @(negedge ref_clk);
    endtask : send
    // fills n cycles with nop; the tests also send some commands into busy and exit windows
    task automatic nop(input int n);
        cmd = 4'h0;
        repeat (n) @(negedge ref_clk);
    endtask : nop
    task automatic power(input logic ck, input logic csn, input logic srf);
        cke          = ck;
        cs_n         = csn;
        self_refresh = srf;
        // a deselected bus carries no meaning, so the code on it is inverted, valid or not
        if (csn)
            cmd = ~cmd;
        @(negedge ref_clk);
    endtask : power
endmodule : lpbs_ctl_model

// ### verification/sdram_bank_state_machine_bench.sv
`timescale 1ns/1ps
module sdram_bank_state_machine_bench;
    logic        ref_clk = 1'b0;
    logic        reset   = 1'b1;
    wire logic   cke, cs_n, auto_pre, self_refresh;
    wire logic [3:0] cmd;
    wire logic [1:0] bank_addr;
    logic [15:0] bank_state;
    logic [2:0]  power_state;
    logic        all_idle, cmd_illegal;
    int          error_cnt = 0;
    int          n_checks  = 0;
    int          cycles    = 0;
    ////////////////////////////////////////////////////////////////////////////
    lpbs_ctl_model m (.ref_clk(ref_clk), .cke(cke), .cs_n(cs_n), .cmd(cmd),
        .bank_addr(bank_addr), .auto_pre(auto_pre), .self_refresh(self_refresh));
    // init count shortened so resetting ends within a short run
    lpbs_bank_fsm #(.INIT5_CYC(10)) dut (.ref_clk(ref_clk), .reset(reset), .cke(cke),
        .cs_n(cs_n), .cmd(cmd), .bank_addr(bank_addr), .auto_pre(auto_pre),
        .self_refresh(self_refresh), .bank_state(bank_state), .power_state(power_state),
        .all_idle(all_idle), .cmd_illegal(cmd_illegal));
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            error_cnt++;
            complete_run();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // index 4 selects the device power state
    function automatic logic [3:0] bs(input int b);
        return (b < 4) ? bank_state[4*b +: 4] : {1'b0, power_state};
    endfunction : bs
    task automatic wait_st(input int b, input logic [3:0] st);
        int i;
        i = 0;
        while (bs(b) !== st && i < 60)
        begin
            m.nop(1);
            i++;
        end
    endtask : wait_st
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_init();
        chk(bs(0), lpbs_pkg::LPBS_POWER_ON);
        m.send(lpbs_pkg::LPBS_CMD_RESET, 2'h0, 1'b0);
        chk(bs(3), lpbs_pkg::LPBS_RESETTING);
        wait_st(0, lpbs_pkg::LPBS_IDLE);
        chk(all_idle, 1'b1);
    endtask : t_init
    task automatic t_write();
        m.send(lpbs_pkg::LPBS_CMD_ACT, 2'h0, 1'b0);
        chk(bs(0), lpbs_pkg::LPBS_ROW_ACTIVATING);
        chk(bs(2), lpbs_pkg::LPBS_IDLE);
        m.send(lpbs_pkg::LPBS_CMD_RD, 2'h0, 1'b0);
        chk(cmd_illegal, 1'b1);
        chk(bs(0), lpbs_pkg::LPBS_ROW_ACTIVATING);
        wait_st(0, lpbs_pkg::LPBS_ACTIVE);
        chk(bs(0), lpbs_pkg::LPBS_ACTIVE);
        m.send(lpbs_pkg::LPBS_CMD_REFA, 2'h0, 1'b0);
        chk(cmd_illegal, 1'b1);
        m.send(lpbs_pkg::LPBS_CMD_WR, 2'h0, 1'b0);
        chk(bs(0), lpbs_pkg::LPBS_WRITING);
        m.send(lpbs_pkg::LPBS_CMD_WR, 2'h0, 1'b0);
        chk(bs(0), lpbs_pkg::LPBS_WRITING);
        m.send(lpbs_pkg::LPBS_CMD_BST, 2'h3, 1'b0);
        chk(bs(0), lpbs_pkg::LPBS_ACTIVE);
        m.send(lpbs_pkg::LPBS_CMD_PRE, 2'h0, 1'b0);
        chk(bs(0), lpbs_pkg::LPBS_PRECHARGING);
        wait_st(0, lpbs_pkg::LPBS_IDLE);
        chk(bs(0), lpbs_pkg::LPBS_IDLE);
    endtask : t_write
    task automatic t_read();
        m.send(lpbs_pkg::LPBS_CMD_ACT, 2'h0, 1'b0);
        wait_st(0, lpbs_pkg::LPBS_ACTIVE);
        m.send(lpbs_pkg::LPBS_CMD_RD, 2'h0, 1'b0);
        chk(bs(0), lpbs_pkg::LPBS_READING);
        m.send(lpbs_pkg::LPBS_CMD_RD, 2'h0, 1'b1);
        chk(bs(0), lpbs_pkg::LPBS_RD_AP);
        m.send(lpbs_pkg::LPBS_CMD_WR, 2'h0, 1'b0);
        chk(cmd_illegal, 1'b1);
        wait_st(0, lpbs_pkg::LPBS_IDLE);
        chk(bs(0), lpbs_pkg::LPBS_IDLE);
        m.send(lpbs_pkg::LPBS_CMD_ACT, 2'h1, 1'b0);
        wait_st(1, lpbs_pkg::LPBS_ACTIVE);
        m.send(lpbs_pkg::LPBS_CMD_MRR, 2'h1, 1'b0);
        chk(bs(1), lpbs_pkg::LPBS_ACTIVE_MRR);
        wait_st(1, lpbs_pkg::LPBS_ACTIVE);
        m.send(lpbs_pkg::LPBS_CMD_RD, 2'h1, 1'b0);
        wait_st(1, lpbs_pkg::LPBS_ACTIVE);
        m.send(lpbs_pkg::LPBS_CMD_BST, 2'h1, 1'b0);
        chk(cmd_illegal, 1'b1);
        m.send(lpbs_pkg::LPBS_CMD_PREA, 2'h2, 1'b0);
        chk(bs(1), lpbs_pkg::LPBS_PRECHARGING);
        wait_st(1, lpbs_pkg::LPBS_IDLE);
        chk(all_idle, 1'b1);
    endtask : t_read
    task automatic t_maint();
        m.send(lpbs_pkg::LPBS_CMD_PRE, 2'h0, 1'b0);
        chk(bs(0), lpbs_pkg::LPBS_PRECHARGING);
        wait_st(0, lpbs_pkg::LPBS_IDLE);
        m.send(lpbs_pkg::LPBS_CMD_REFA, 2'h0, 1'b0);
        chk(bs(3), lpbs_pkg::LPBS_REFRESHING);
        m.send(lpbs_pkg::LPBS_CMD_MRR, 2'h0, 1'b0);
        chk(cmd_illegal, 1'b1);
        wait_st(3, lpbs_pkg::LPBS_IDLE);
        chk(all_idle, 1'b1);
        m.send(lpbs_pkg::LPBS_CMD_MRW, 2'h0, 1'b0);
        chk(bs(1), lpbs_pkg::LPBS_MR_WRITING);
        wait_st(1, lpbs_pkg::LPBS_IDLE);
        m.send(lpbs_pkg::LPBS_CMD_MRR, 2'h0, 1'b0);
        chk(bs(0), lpbs_pkg::LPBS_IDLE_MRR);
        wait_st(0, lpbs_pkg::LPBS_IDLE);
        chk(bs(0), lpbs_pkg::LPBS_IDLE);
    endtask : t_maint
    task automatic t_power();
        m.power(1'b0, 1'b1, 1'b0);
        chk(bs(4), lpbs_pkg::LPBS_PWR_PD);
        repeat (3) @(negedge ref_clk);
        chk(bs(4), lpbs_pkg::LPBS_PWR_PD);
        m.power(1'b1, 1'b1, 1'b0);
        m.power(1'b1, 1'b0, 1'b0);
        wait_st(4, lpbs_pkg::LPBS_PWR_RUN);
        chk(bs(4), lpbs_pkg::LPBS_PWR_RUN);
        m.power(1'b0, 1'b0, 1'b1);
        chk(bs(4), lpbs_pkg::LPBS_PWR_SREF);
        m.power(1'b1, 1'b1, 1'b0);
        m.power(1'b1, 1'b0, 1'b0);
        m.send(lpbs_pkg::LPBS_CMD_ACT, 2'h0, 1'b0);
        chk(bs(0), lpbs_pkg::LPBS_IDLE);
        chk(cmd_illegal, 1'b0);
        wait_st(4, lpbs_pkg::LPBS_PWR_RUN);
        chk(bs(4), lpbs_pkg::LPBS_PWR_RUN);
    endtask : t_power
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (12) @(negedge ref_clk);
        reset = 1'b0;
        m.nop(2);
        t_init();
        t_write();
        t_read();
        t_maint();
        t_power();
        complete_run();
    end
endmodule : sdram_bank_state_machine_bench
